// ==== hw/sas_params.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the converter sequencer.
  Assumes it is included by bare name from the package; the design modules use its macros without including it.
*/
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

`define SAS_OFS_MODE        32'h0ffff3c0
`define SAS_OFS_CHAN        32'hfffff3c2
`define SAS_OFS_RESULT      32'hfffff3c4
`define SAS_OFS_RESULT_HIGH 32'hfffff3c6

`define SAS_BIT_EN          7
`define SAS_BIT_TRIG        6
`define SAS_BIT_PS          0

`define SAS_RST_MODE        8'h00
`define SAS_RST_CHAN        4'h0
`define SAS_RST_RESULT      10'h000
`define SAS_CHAN_MAX        4'hb

// Conversion and stabilization times in internal clock periods
`define SAS_CONV_C0         8'd168
`define SAS_CONV_C1         8'd120
`define SAS_CONV_C2         8'd84
`define SAS_CONV_C3         8'd60
`define SAS_CONV_C4         8'd48
`define SAS_CONV_C5         8'd36
`define SAS_CONV_C7         8'd12
`define SAS_STAB_C0         8'd64
`define SAS_STAB_C1         8'd60
`define SAS_STAB_C2         8'd42
`define SAS_STAB_C3         8'd30
`define SAS_STAB_C4         8'd24
`define SAS_STAB_C5         8'd18
`define SAS_STAB_C7         8'd6
`define SAS_STEP_SLOTS      8'd12
`define SAS_SAMPLE_SLOTS    8'd2

`endif

// ==== hw/sas_pkg.sv ====
/*
  Types shared by the converter sequencer modules.
  Assumes the params header is on the include path.
*/
package sas_pkg;
  `include "sas_params.svh"

  typedef enum logic [4:0] {
    SAS_IDLE   = 5'b00001,
    SAS_WAIT   = 5'b00010,
    SAS_STAB   = 5'b00100,
    SAS_SAMPLE = 5'b01000,
    SAS_CONV   = 5'b10000
  } sas_state_type;

  typedef struct packed {
    logic       en;
    logic       trig;
    logic [2:0] time_sel;
    logic [1:0] edge_sel;
    logic       ps;
  } sas_mode_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic        rd;
    logic [1:0]  be;
    logic [15:0] wdata;
  } sas_bus_req_type;
endpackage

// ==== hw/sas_step_timer.sv ====
/*
  Down-counting phase timer: ticks in the last cycle of a loaded interval.
  Assumes a load value of at least one; a load in a tick cycle starts the next interval at once.
*/
`timescale 1ns/1ns
module sas_step_timer
  import sas_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              tick
);
  logic [W-1:0] count_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Not gated by load: the sequencer loads on tick, and gating would close a combinational loop
  assign tick = (count_q == W'(1));
endmodule

// ==== hw/sas_top.sv ====
/*
  Successive-approximation converter sequencer with mode, channel and result registers.
  Assumes a 16-bit CPU register port synchronous to clk_sys and an analog front end
  that settles its comparator within one step for the trial code on dac_code.
*/
`timescale 1ns/1ns
//
// Contract
// - Ten-bit result from one of twelve channels
// - Trigger start converts once, then interrupts
// - Software start converts repeatedly, interrupts each time
// - Resolve MSB first, copy to result
// - Result word: value high, low six zero
// - High byte view gives top eight bits
// - Reset clears result word and byte
// - Unselected analog pins stay digital inputs
// - Mode bit 7 enables conversion; resets zero
// - Mode bit 6 selects trigger start
// - Edge bits pick none, fall, rise, both
// - Time code picks conversion clock count
// - Power save adds matching stabilization interval
// - Mode bit 0 turns comparator off idle
// - Four-bit channel code, upper bits zero
// - Mode or channel write restarts conversion
// - Trial bits nine down to zero
// - Enabled trigger mode waits for edge
module sas_top
  import sas_pkg::*;
#(
  parameter int CHANNELS = 12,
  parameter int RES_BITS = 10
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire sas_bus_req_type     bus_req,
  output logic [15:0]              rd_data_q,
  output logic                     rd_valid_q,
  input  wire logic                ext_trigger_in,
  input  wire logic                cmp_result,
  output logic [RES_BITS-1:0]      dac_code_q,
  output logic                     sample_hold_q,
  output logic                     comparator_on_q,
  output logic [CHANNELS-1:0]      analog_input_pins_q,
  output logic [CHANNELS-1:0]      port_in_en_q,
  output logic                     conv_done_irq_q
);
  sas_mode_type        converter_mode_reg_q;
  logic [3:0]          channel_select_reg_q;
  logic [RES_BITS-1:0] result_word_q;
  logic [RES_BITS-1:0] approx_shift_reg_q;
  logic [3:0]          bit_idx_q;
  logic                trig_prev_q;
  sas_state_type       state_q;
  sas_state_type       state_d;
  logic                tload;
  logic [7:0]          tval;
  logic                tick;

  function automatic logic [7:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'h0:    conv_cycles = `SAS_CONV_C0;
      3'h1:    conv_cycles = `SAS_CONV_C1;
      3'h2:    conv_cycles = `SAS_CONV_C2;
      3'h3:    conv_cycles = `SAS_CONV_C3;
      3'h4:    conv_cycles = `SAS_CONV_C4;
      3'h5:    conv_cycles = `SAS_CONV_C5;
      3'h7:    conv_cycles = `SAS_CONV_C7;
      default: conv_cycles = `SAS_CONV_C0;
    endcase
  endfunction

  function automatic logic [7:0] stab_cycles(input logic [2:0] code);
    case (code)
      3'h0:    stab_cycles = `SAS_STAB_C0;
      3'h1:    stab_cycles = `SAS_STAB_C1;
      3'h2:    stab_cycles = `SAS_STAB_C2;
      3'h3:    stab_cycles = `SAS_STAB_C3;
      3'h4:    stab_cycles = `SAS_STAB_C4;
      3'h5:    stab_cycles = `SAS_STAB_C5;
      3'h7:    stab_cycles = `SAS_STAB_C7;
      default: stab_cycles = `SAS_STAB_C0;
    endcase
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction

  // Every listed conversion time is a multiple of twelve, so two sample slots and ten steps fill it exactly
  logic [7:0] step_len;
  assign step_len = conv_cycles(converter_mode_reg_q.time_sel) / `SAS_STEP_SLOTS;

  logic wr_mode;
  logic wr_chan;
  logic rd_any;
  assign wr_mode = bus_req.wr && bus_req.be[0] && hit(bus_req.addr, `SAS_OFS_MODE);
  assign wr_chan = bus_req.wr && bus_req.be[0] && hit(bus_req.addr, `SAS_OFS_CHAN);
  assign rd_any  = bus_req.rd;

  sas_mode_type mode_new;
  assign mode_new = wr_mode ? sas_mode_type'(bus_req.wdata[7:0]) : converter_mode_reg_q;

  logic edge_rise;
  logic edge_fall;
  logic trig_hit;
  assign edge_rise = ext_trigger_in && !trig_prev_q;
  assign edge_fall = !ext_trigger_in && trig_prev_q;
  assign trig_hit  = (converter_mode_reg_q.edge_sel[1] && edge_rise) ||
                     (converter_mode_reg_q.edge_sel[0] && edge_fall);

  logic last_step;
  assign last_step = (bit_idx_q == 4'h0);

  always_comb begin
    state_d = state_q;
    tload   = 1'b0;
    tval    = 8'h01;
    if (wr_mode || wr_chan) begin
      // A mode or channel write drops the running conversion and starts over
      tload = 1'b1;
      if (!mode_new.en) begin
        state_d = SAS_IDLE;
      end else if (mode_new.trig) begin
        state_d = SAS_WAIT;
      end else if (mode_new.ps) begin
        state_d = SAS_STAB;
        tval    = stab_cycles(mode_new.time_sel);
      end else begin
        state_d = SAS_SAMPLE;
        tval    = 8'((conv_cycles(mode_new.time_sel) / `SAS_STEP_SLOTS) * `SAS_SAMPLE_SLOTS);
      end
    end else begin
      case (state_q)
        SAS_IDLE: begin
          state_d = SAS_IDLE;
        end
        SAS_WAIT: begin
          if (trig_hit) begin
            tload = 1'b1;
            if (converter_mode_reg_q.ps) begin
              state_d = SAS_STAB;
              tval    = stab_cycles(converter_mode_reg_q.time_sel);
            end else begin
              state_d = SAS_SAMPLE;
              tval    = 8'(step_len * `SAS_SAMPLE_SLOTS);
            end
          end
        end
        SAS_STAB: begin
          if (tick) begin
            state_d = SAS_SAMPLE;
            tload   = 1'b1;
            tval    = 8'(step_len * `SAS_SAMPLE_SLOTS);
          end
        end
        SAS_SAMPLE: begin
          if (tick) begin
            state_d = SAS_CONV;
            tload   = 1'b1;
            tval    = step_len;
          end
        end
        SAS_CONV: begin
          if (tick && last_step) begin
            tload = 1'b1;
            if (converter_mode_reg_q.trig) begin
              state_d = SAS_WAIT;
            end else if (converter_mode_reg_q.ps) begin
              state_d = SAS_STAB;
              tval    = stab_cycles(converter_mode_reg_q.time_sel);
            end else begin
              state_d = SAS_SAMPLE;
              tval    = 8'(step_len * `SAS_SAMPLE_SLOTS);
            end
          end else if (tick) begin
            tload = 1'b1;
            tval  = step_len;
          end
        end
        default: begin
          state_d = SAS_IDLE;
        end
      endcase
    end
  end

  sas_step_timer #(
    .W (8)
  ) u_timer (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .load     (tload),
    .load_val (tval),
    .tick     (tick)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= SAS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      converter_mode_reg_q <= sas_mode_type'(`SAS_RST_MODE);
      channel_select_reg_q <= `SAS_RST_CHAN;
    end else begin
      if (wr_mode) begin
        converter_mode_reg_q <= mode_new;
      end
      if (wr_chan) begin
        channel_select_reg_q <= bus_req.wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= ext_trigger_in;
    end
  end

  // Ladder copy moves with the APPROX_SHIFT_REG so a one-cycle step still decides on its own trial code
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      approx_shift_reg_q <= '0;
      dac_code_q         <= '0;
      bit_idx_q          <= 4'h0;
    end else if (state_q == SAS_SAMPLE && state_d == SAS_CONV) begin
      approx_shift_reg_q <= RES_BITS'(1) << (RES_BITS - 1);
      dac_code_q         <= RES_BITS'(1) << (RES_BITS - 1);
      bit_idx_q          <= 4'(RES_BITS - 1);
    end else if (state_q == SAS_CONV && tick && !(wr_mode || wr_chan)) begin
      approx_shift_reg_q[bit_idx_q] <= cmp_result;
      dac_code_q[bit_idx_q]         <= cmp_result;
      if (!last_step) begin
        approx_shift_reg_q[4'(bit_idx_q - 4'h1)] <= 1'b1;
        dac_code_q[4'(bit_idx_q - 4'h1)]         <= 1'b1;
        bit_idx_q                                <= 4'(bit_idx_q - 4'h1);
      end
    end
  end

  logic done_now;
  assign done_now = (state_q == SAS_CONV) && tick && last_step && !(wr_mode || wr_chan);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      result_word_q   <= `SAS_RST_RESULT;
      conv_done_irq_q <= 1'b0;
    end else begin
      conv_done_irq_q <= done_now;
      if (done_now) begin
        result_word_q <= {approx_shift_reg_q[RES_BITS-1:1], cmp_result};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_any;
      if (!rd_any) begin
        rd_data_q <= 16'h0000;
      end else if (hit(bus_req.addr, `SAS_OFS_MODE)) begin
        rd_data_q <= {8'h00, converter_mode_reg_q};
      end else if (hit(bus_req.addr, `SAS_OFS_CHAN)) begin
        rd_data_q <= {12'h000, channel_select_reg_q};
      end else if (hit(bus_req.addr, `SAS_OFS_RESULT)) begin
        rd_data_q <= {result_word_q, 6'h00};
      end else if (hit(bus_req.addr, `SAS_OFS_RESULT_HIGH)) begin
        rd_data_q <= {8'h00, result_word_q[RES_BITS-1:RES_BITS-8]};
      end else begin
        rd_data_q <= 16'h0000;
      end
    end
  end

  // Out-of-range channel codes route no pin; the converter still runs on whatever it holds
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      analog_input_pins_q <= '0;
      port_in_en_q        <= '1;
      sample_hold_q       <= 1'b0;
      comparator_on_q     <= 1'b1;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        analog_input_pins_q[i] <= (channel_select_reg_q == 4'(i));
        port_in_en_q[i]        <= (channel_select_reg_q != 4'(i));
      end
      sample_hold_q   <= (state_d == SAS_SAMPLE);
      comparator_on_q <= converter_mode_reg_q.en || !converter_mode_reg_q.ps;
    end
  end

  res_low_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_any && hit(bus_req.addr, `SAS_OFS_RESULT) |=> rd_data_q[5:0] == 6'h00 && rd_valid_q)
    else $error("result low bits not zero");
  high_byte_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_any && hit(bus_req.addr, `SAS_OFS_RESULT_HIGH) |=> rd_data_q == {8'h00, $past(result_word_q[9:2])})
    else $error("high byte view wrong");
  reset_clear_a: assert property (@(posedge clk_sys)
    sys_rst |=> result_word_q == 10'h000 && converter_mode_reg_q == 8'h00)
    else $error("reset did not clear registers");
  disable_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mode && !bus_req.wdata[7] |=> state_q == SAS_IDLE ##1 !conv_done_irq_q)
    else $error("disabled converter still running");
  trig_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_mode && bus_req.wdata[7] && bus_req.wdata[6] |=> state_q == SAS_WAIT)
    else $error("trigger mode did not wait");
  hw_single_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_done_irq_q && converter_mode_reg_q.trig && !$past(wr_mode) |-> state_q == SAS_WAIT)
    else $error("trigger conversion did not stop");
  sw_repeat_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_done_irq_q && converter_mode_reg_q.en && !converter_mode_reg_q.trig && !$past(wr_mode || wr_chan)
    |-> state_q inside {SAS_STAB, SAS_SAMPLE})
    else $error("software conversion did not repeat");
  sar_msb_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_q == SAS_CONV) |-> approx_shift_reg_q == 10'h200 && bit_idx_q == 4'h9)
    else $error("approximation did not start at bit 9");
  pin_split_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (analog_input_pins_q & port_in_en_q) == '0 && (analog_input_pins_q | port_in_en_q) == '1)
    else $error("pin ownership overlap");
  cmp_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !comparator_on_q |-> $past(!converter_mode_reg_q.en && converter_mode_reg_q.ps))
    else $error("comparator off while enabled");
  restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == SAS_CONV && wr_chan && converter_mode_reg_q.en && !converter_mode_reg_q.trig
    |=> state_q != SAS_CONV)
    else $error("write did not restart conversion");

  hw_done_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    conv_done_irq_q && converter_mode_reg_q.trig);
  sw_twice_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    conv_done_irq_q ##[1:400] conv_done_irq_q);
  restart_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == SAS_CONV && (wr_mode || wr_chan));
endmodule

// ==== test/sas_front_model.sv ====
/*
  Behavioural analog front end: sample-hold, resistor ladder and comparator.
  Assumes one 10-bit level per channel on vin, channel 0 in the low bits.
*/
`timescale 1ns/1ns
module sas_front_model (
  input  wire logic         clk_sys,
  input  wire logic [119:0] vin,
  input  wire logic [9:0]   dac_code_q,
  input  wire logic         sample_hold_q,
  input  wire logic         comparator_on_q,
  input  wire logic [11:0]  analog_input_pins_q,
  output logic              cmp_result
);
  logic [9:0] held_q;
  logic       junk_q = 1'b0;
  // Held level follows the routed pin only while sampling
  always_ff @(posedge clk_sys) begin
    junk_q <= ~junk_q;
    for (int i = 0; i < 12; i++) begin
      if (sample_hold_q && analog_input_pins_q[i]) begin
        held_q <= vin[i*10 +: 10];
      end
    end
  end
  // Unpowered or unrouted comparator gives no decision, only a toggling level
  assign cmp_result = (comparator_on_q && |analog_input_pins_q) ? (held_q >= dac_code_q) : junk_q;
endmodule

// ==== test/sas_top_test.sv ====
/*
  Self-checking bench of the converter sequencer: register port, timing per code, trigger edges.
  Assumes the design package and the front end model are compiled before it.
*/
`timescale 1ns/1ns
module sas_top_test;
  import sas_pkg::*;
  localparam logic [31:0] A_MODE = 32'h0ffff3c0;
  localparam logic [31:0] A_CHAN = 32'hfffff3c2;
  localparam logic [31:0] A_RES  = 32'hfffff3c4;
  localparam logic [31:0] A_RESH = 32'hfffff3c6;
  localparam logic [31:0] A_NONE = 32'hfffff3ca;
  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  sas_bus_req_type bus_req = '0;
  logic            ext_trigger_in = 1'b0;
  logic            cmp_result;
  logic [119:0]    vin = '0;
  logic [15:0]     rd_data_q;
  logic            rd_valid_q;
  logic [9:0]      dac_code_q;
  logic            sample_hold_q;
  logic            comparator_on_q;
  logic            conv_done_irq_q;
  logic [11:0]     analog_input_pins_q;
  logic [11:0]     port_in_en_q;
  int              error_cnt = 0;
  int              checks_done = 0;
  int              n;

  always #10 clk_sys = ~clk_sys;

  sas_top sas_top_i (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .bus_req             (bus_req),
    .rd_data_q           (rd_data_q),
    .rd_valid_q          (rd_valid_q),
    .ext_trigger_in      (ext_trigger_in),
    .cmp_result          (cmp_result),
    .dac_code_q          (dac_code_q),
    .sample_hold_q       (sample_hold_q),
    .comparator_on_q     (comparator_on_q),
    .analog_input_pins_q (analog_input_pins_q),
    .port_in_en_q        (port_in_en_q),
    .conv_done_irq_q     (conv_done_irq_q)
  );

  sas_front_model sas_front_model_i (
    .clk_sys             (clk_sys),
    .vin                 (vin),
    .dac_code_q          (dac_code_q),
    .sample_hold_q       (sample_hold_q),
    .comparator_on_q     (comparator_on_q),
    .analog_input_pins_q (analog_input_pins_q),
    .cmp_result          (cmp_result)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Byte-wide writes only, as software must use
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wr: 1'b1, rd: 1'b0, be: 2'b01, wdata: {8'h00, d}};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wr: 1'b0, rd: 1'b1, be: 2'b11, wdata: 16'h0000};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    check({15'h0000, rd_valid_q}, 16'h0001);
    check(rd_data_q, exp);
  endtask

  // Counts edges after a start edge up to the interrupt pulse; must marks a pulse as required
  task automatic wait_irq(input int lim, output int cnt, input bit must);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (conv_done_irq_q !== 1'b1 && cnt < lim);
    if (must && conv_done_irq_q !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, conv_done_irq_q, 1'b1);
      report_and_stop();
    end
  endtask

  function automatic int total(input logic [2:0] c, input logic ps);
    int conv[8] = '{168, 120, 84, 60, 48, 36, 168, 12};
    int stab[8] = '{64, 60, 42, 30, 24, 18, 64, 6};
    return conv[c] + (ps ? stab[c] : 0);
  endfunction

  function automatic logic [9:0] sar_model(input logic [9:0] v);
    logic [9:0] s;
    s = 10'h000;
    for (int k = 9; k >= 0; k--) begin
      s[k] = 1'b1;
      if (v < s) begin
        s[k] = 1'b0;
      end
    end
    return s;
  endfunction

  initial begin
    logic [7:0] m;
    logic [3:0] ch;
    logic [9:0] s;
    void'($urandom(32'h2742));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(A_RES, 16'h0000);
    rd(A_RESH, 16'h0000);
    rd(A_MODE, 16'h0000);
    rd(A_NONE, 16'h0000);
    check({4'h0, port_in_en_q}, 16'h0ffe);
    wr(A_CHAN, 8'hfb);
    rd(A_CHAN, 16'h000b);
    check({4'h0, analog_input_pins_q}, 16'h0800);
    check({4'h0, port_in_en_q}, 16'h07ff);
    wr(A_CHAN, 8'h0d);
    @(posedge clk_sys);
    #1;
    check({4'h0, analog_input_pins_q}, 16'h0000);
    wr(A_MODE, 8'h01);
    @(posedge clk_sys);
    #1;
    check({15'h0000, comparator_on_q}, 16'h0000);
    // Every time code, each followed by a result read
    for (int i = 0; i < 8; i++) begin
      ch = 4'($urandom_range(11));
      m = {2'b10, 3'(i), 2'($urandom_range(3)), 1'($urandom_range(1))};
      vin <= 120'({$urandom, $urandom, $urandom, $urandom});
      wr(A_CHAN, {4'h0, ch});
      wr(A_MODE, m);
      wait_irq(400, n, 1'b1);
      check(16'(n), 16'(total(3'(i), m[0])));
      check({15'h0000, comparator_on_q}, 16'h0001);
      wait_irq(400, n, 1'b1);
      check(16'(n), 16'(total(3'(i), m[0])));
      s = sar_model(vin[ch*10 +: 10]);
      rd(A_RES, {s, 6'h00});
      rd(A_RESH, {8'h00, s[9:2]});
    end
    // Channel rewrite mid-conversion restarts the full count
    // Longest time code; at a 20 ns clock no code reaches the software time window
    wr(A_MODE, 8'h80);
    repeat (50) @(posedge clk_sys);
    wr(A_CHAN, {4'h0, ch});
    wait_irq(400, n, 1'b1);
    check(16'(n), 16'(total(3'd0, 1'b0)));
    wr(A_MODE, 8'hc0);
    wr(A_RES, 8'h5a);
    rd(A_RES, {s, 6'h00});
    rd(A_MODE, 16'h00c0);
    // Each edge selection against a rise and a fall
    for (int e = 0; e < 4; e++) begin
      wr(A_MODE, {2'b11, 3'd7, 2'(e), 1'b0});
      repeat (3) @(posedge clk_sys);
      ext_trigger_in <= 1'b1;
      wait_irq(40, n, 1'b0);
      check(16'(conv_done_irq_q), 16'(e[1]));
      wait_irq(40, n, 1'b0);
      check(16'(conv_done_irq_q), 16'h0000);
      @(posedge clk_sys);
      ext_trigger_in <= 1'b0;
      wait_irq(40, n, 1'b0);
      check(16'(conv_done_irq_q), 16'(e[0]));
      wait_irq(40, n, 1'b0);
      check(16'(conv_done_irq_q), 16'h0000);
    end
    report_and_stop();
  end
endmodule
